// ### hw/ascp_defines.vh
`ifndef ASCP_DEFINES_VH
`define ASCP_DEFINES_VH

// control word layout: header, channel, range code
`define ASCP_WORD_W        8
`define ASCP_HDR_MSB       7
`define ASCP_HDR_LSB       6
`define ASCP_HDR_CODE      2'h2
`define ASCP_CH_MSB        5
`define ASCP_CH_LSB        3
`define ASCP_RNG_MSB       2
`define ASCP_RNG_LSB       0

// stored configuration: {channel, range}
`define ASCP_CFG_W         6
`define ASCP_CFG_CH_MSB    5
`define ASCP_CFG_CH_LSB    3
`define ASCP_CFG_RNG_MSB   2
`define ASCP_CFG_RNG_LSB   0
`define ASCP_CFG_RESET     6'h07

// range code bits
`define ASCP_RNG_BIPOLAR   1
`define ASCP_RNG_FULL      0
`define ASCP_RNG_WIDE      2

// result frame: result, channel, range, pad
`define ASCP_RES_W         16
`define ASCP_OUT_W         24
`define ASCP_OUT_MSB       23
`define ASCP_OUT_PAD       2'h0

// counters and depths
`define ASCP_BITCNT_W      3
`define ASCP_BITCNT_LAST   3'h7
`define ASCP_SEQ_DEPTH     8
`define ASCP_SEQ_AW        3
`define ASCP_LEN_W         4
`define ASCP_FIFO_DEPTH    8
`define ASCP_FIFO_AW       3

`endif

// ### hw/ascp_fifo.v
`timescale 1ns/1ps
`include "ascp_defines.vh"

module ascp_fifo #(
    parameter WIDTH = 7,
    parameter DEPTH = `ASCP_FIFO_DEPTH,
    parameter AW    = `ASCP_FIFO_AW
) (
    // clock and reset
    input  wire             i_mclk,
    input  wire             i_sys_rst,
    input  wire             i_clk_en,
    // filling side
    input  wire             i_in_valid,
    output wire             o_in_ready,
    input  wire [WIDTH-1:0] i_in_data,
    // draining side
    output wire             o_out_valid,
    input  wire             i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);

    reg  [WIDTH-1:0] mem [0:DEPTH-1];   // storage, no reset needed
    reg  [AW-1:0]    wr_ptr_reg;        // next write slot
    reg  [AW-1:0]    rd_ptr_reg;        // next read slot
    reg  [AW:0]      count_reg;         // words held
    wire             push;
    wire             pop;

    // flags from the count
    assign o_in_ready  = (count_reg != DEPTH[AW:0]);
    assign o_out_valid = (count_reg != {(AW+1){1'b0}});
    assign o_out_data  = mem[rd_ptr_reg];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    // data array
    always @(posedge i_mclk) begin
        if (i_clk_en && push) begin
            mem[wr_ptr_reg] <= i_in_data;
        end
    end

    // pointers and count; push and pop may share a cycle
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else if (i_clk_en) begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule // ascp_fifo

// ### hw/ascp_seq_mem.v
`timescale 1ns/1ps
`include "ascp_defines.vh"

module ascp_seq_mem #(
    parameter WIDTH = `ASCP_CFG_W,
    parameter DEPTH = `ASCP_SEQ_DEPTH,
    parameter AW    = `ASCP_SEQ_AW
) (
    // clock and reset
    input  wire             i_mclk,
    input  wire             i_sys_rst,
    input  wire             i_clk_en,
    // write port
    input  wire             i_we,
    input  wire [AW-1:0]    i_waddr,
    input  wire [WIDTH-1:0] i_wdata,
    // registered read port
    input  wire [AW-1:0]    i_raddr,
    output reg  [WIDTH-1:0] o_rdata
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];    // sequence entries

    // write port
    always @(posedge i_mclk) begin
        if (i_clk_en && i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // registered read, one cycle late
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= {WIDTH{1'b0}};
        end else if (i_clk_en) begin
            o_rdata <= mem[i_raddr];
        end
    end

endmodule // ascp_seq_mem

// ### hw/ascp_top.v
`timescale 1ns/1ps
`include "ascp_defines.vh"

// Behaviour
// (RULE_01) single-ended: sample input, advance output on rise
// (RULE_02) single-ended host captures output on rising edges
// (RULE_03) single-ended clock may idle high or low
// (RULE_04) echo clock toggles per rise, half rate
// (RULE_05) echo clock forced low when busy falls
// (RULE_06) host uses both echo edges or ignores it
// (RULE_07) shift out latest result with its configuration
// (RULE_08) all-zero input keeps the programmed sequence
// (RULE_09) outputs enabled only while select is low
// (RULE_10) clock edges ignored while select is high
// (RULE_11) unused mode's pins kept high impedance
// (RULE_12) differential: sample input on both edges
// (RULE_13) differential: advance output on both edges
// (RULE_14) differential clock idles low, also around select
// (RULE_15) differential: forward clock copy aligned with data
// (RULE_16) termination enabled only while select is low
// (RULE_17) control word: header 10, channel, range
// (RULE_18) bipolar codes two's complement, others straight
// (RULE_19) odd code full span, wide codes double
// (RULE_20) header 7:6, channel 5:3, range 2:0, MSB first
// (RULE_21) channel field picks one of eight
// (RULE_22) conversion start edge ignores select and bus
// (RULE_23) busy high from start until conversion done
// (RULE_24) mode pin high selects differential mode
module ascp_top (
    // clock, reset, enable
    input  wire                   i_mclk,
    input  wire                   i_sys_rst,
    input  wire                   i_clk_en,
    // pins from the host
    input  wire                   i_mode_diff,
    input  wire                   i_cs_n,
    input  wire                   i_shift_clock_in,
    input  wire                   i_serial_control_in,
    input  wire                   i_diff_shift_clock_in,
    input  wire                   i_diff_serial_control_in,
    input  wire                   i_conversion_start,
    // single-ended outputs, enables low while driving
    output reg                    o_serial_result_out,
    output reg                    o_serial_result_oe_n,
    output reg                    o_echoed_shift_clock_out,
    output reg                    o_echoed_shift_clock_oe_n,
    // differential outputs, enables low while driving
    output reg                    o_diff_serial_result_out,
    output reg                    o_diff_serial_result_oe_n,
    output reg                    o_diff_shift_clock_out,
    output reg                    o_diff_shift_clock_oe_n,
    // input pad controls
    output reg                    o_se_input_en,
    output reg                    o_diff_term_en,
    // link to the conversion core
    input  wire                   i_core_done,
    input  wire [`ASCP_RES_W-1:0] i_core_result,
    output reg                    o_core_start,
    output reg  [2:0]             o_core_channel,
    output reg  [2:0]             o_core_range,
    output reg                    o_core_span_wide,
    output reg                    o_core_span_full,
    output reg                    o_busy,
    // control word queue status
    output reg                    o_word_ready
);

    localparam ST_IDLE = 2'b01;          // waiting for a start edge
    localparam ST_CONV = 2'b10;          // conversion under way

    // synchronisers: stage 1 is read only by stage 2
    reg        mode_s1_reg, mode_s2_reg;
    reg        cs_s1_reg, cs_s2_reg, cs_s3_reg;
    reg        ck_s1_reg, ck_s2_reg, ck_s3_reg;
    reg        dat_s1_reg, dat_s2_reg;
    reg        cnv_s1_reg, cnv_s2_reg, cnv_s3_reg;

    // shift engine
    reg  [`ASCP_WORD_W-1:0]   in_sh_reg;     // incoming bits
    reg  [`ASCP_BITCNT_W-1:0] bit_cnt_reg;   // bit within a word
    reg  [`ASCP_OUT_W-1:0]    out_sh_reg;    // outgoing frame
    reg  [`ASCP_OUT_W-1:0]    out_word_reg;  // latest result frame
    reg                       first_reg;     // next word opens a sequence

    // sequencer
    reg  [1:0]                state_reg;
    reg  [`ASCP_SEQ_AW-1:0]   wr_ptr_reg;
    reg  [`ASCP_SEQ_AW-1:0]   rd_ptr_reg;
    reg  [`ASCP_LEN_W-1:0]    len_reg;
    reg  [`ASCP_CFG_W-1:0]    conv_cfg_reg;  // config of running conversion

    // combinational
    wire                      raw_ck;
    wire                      raw_dat;
    wire                      sel;
    wire                      ck_rise;
    wire                      ck_fall;
    wire                      act_edge;
    wire [`ASCP_WORD_W-1:0]   word_now;
    wire                      word_done;
    wire                      word_push;
    wire                      fifo_in_ready;
    wire                      fifo_out_valid;
    wire                      fifo_out_ready;
    wire [`ASCP_CFG_W:0]      fifo_out_data;
    wire                      seq_we;
    wire [`ASCP_SEQ_AW-1:0]   seq_waddr;
    wire [`ASCP_CFG_W-1:0]    seq_rdata;
    wire [`ASCP_CFG_W-1:0]    next_cfg;
    wire                      cnv_rise;
    wire [`ASCP_RES_W-1:0]    fmt_result;
    wire                      dout_next;

    // strapped mode picks the pins
    assign raw_ck  = mode_s2_reg ? i_diff_shift_clock_in
                                 : i_shift_clock_in;    // RULE_24
    assign raw_dat = mode_s2_reg ? i_diff_serial_control_in
                                 : i_serial_control_in;

    // edges right at select changes are lost
    assign sel      = ~cs_s2_reg & ~cs_s3_reg;           // RULE_10
    assign ck_rise  = ck_s2_reg & ~ck_s3_reg;
    assign ck_fall  = ~ck_s2_reg & ck_s3_reg;
    // diff: both edges; single-ended: rise
    assign act_edge = sel & (ck_rise |
                             (mode_s2_reg & ck_fall));   // RULE_01 RULE_12

    // MSB first, done on the eighth bit
    assign word_now  = {in_sh_reg[`ASCP_WORD_W-2:0], dat_s2_reg}; // RULE_20
    assign word_done = act_edge & (bit_cnt_reg == `ASCP_BITCNT_LAST);
    // only headed words are queued
    assign word_push = word_done &
        (word_now[`ASCP_HDR_MSB:`ASCP_HDR_LSB] == `ASCP_HDR_CODE); // RULE_17 RULE_08

    // drain only while idle, so the sequence holds mid-conversion
    assign fifo_out_ready = (state_reg == ST_IDLE);
    assign seq_we         = fifo_out_valid & fifo_out_ready;
    assign seq_waddr      = fifo_out_data[`ASCP_CFG_W] ?
                            {`ASCP_SEQ_AW{1'b0}} : wr_ptr_reg;

    // empty sequence: reset config
    assign next_cfg = (len_reg == {`ASCP_LEN_W{1'b0}}) ?
                      `ASCP_CFG_RESET : seq_rdata;       // RULE_08

    assign cnv_rise = cnv_s2_reg & ~cnv_s3_reg;          // RULE_22

    // data leaves with the edge that shifts it, like the echo clocks
    assign dout_next = act_edge ? out_sh_reg[`ASCP_OUT_MSB-1]
                                : out_sh_reg[`ASCP_OUT_MSB]; // RULE_04

    // bipolar codes: flip MSB of the core's offset code
    assign fmt_result = {i_core_result[`ASCP_RES_W-1] ^
                         conv_cfg_reg[`ASCP_RNG_BIPOLAR],
                         i_core_result[`ASCP_RES_W-2:0]}; // RULE_18

    // incoming control words
    ascp_fifo #(
        .WIDTH (`ASCP_CFG_W + 1),
        .DEPTH (`ASCP_FIFO_DEPTH),
        .AW    (`ASCP_FIFO_AW)
    ) u_fifo (
        .i_mclk      (i_mclk),
        .i_sys_rst   (i_sys_rst),
        .i_clk_en    (i_clk_en),
        .i_in_valid  (word_push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   ({first_reg,
                       word_now[`ASCP_CH_MSB:`ASCP_RNG_LSB]}),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_out_ready),
        .o_out_data  (fifo_out_data)
    );

    // programmed channel sequence
    ascp_seq_mem #(
        .WIDTH (`ASCP_CFG_W),
        .DEPTH (`ASCP_SEQ_DEPTH),
        .AW    (`ASCP_SEQ_AW)
    ) u_seq (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_clk_en  (i_clk_en),
        .i_we      (seq_we),
        .i_waddr   (seq_waddr),
        .i_wdata   (fifo_out_data[`ASCP_CFG_W-1:0]),
        .i_raddr   (rd_ptr_reg),
        .o_rdata   (seq_rdata)
    );

    // two-flop synchronisers for every pin
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mode_s1_reg <= 1'b0;
            mode_s2_reg <= 1'b0;
            cs_s1_reg   <= 1'b1;
            cs_s2_reg   <= 1'b1;
            cs_s3_reg   <= 1'b1;
            ck_s1_reg   <= 1'b0;
            ck_s2_reg   <= 1'b0;
            ck_s3_reg   <= 1'b0;
            dat_s1_reg  <= 1'b0;
            dat_s2_reg  <= 1'b0;
            cnv_s1_reg  <= 1'b0;
            cnv_s2_reg  <= 1'b0;
            cnv_s3_reg  <= 1'b0;
        end else if (i_clk_en) begin
            mode_s1_reg <= i_mode_diff;
            mode_s2_reg <= mode_s1_reg;
            cs_s1_reg   <= i_cs_n;
            cs_s2_reg   <= cs_s1_reg;
            cs_s3_reg   <= cs_s2_reg;
            ck_s1_reg   <= raw_ck;
            ck_s2_reg   <= ck_s1_reg;
            ck_s3_reg   <= ck_s2_reg;
            dat_s1_reg  <= raw_dat;
            dat_s2_reg  <= dat_s1_reg;
            cnv_s1_reg  <= i_conversion_start;
            cnv_s2_reg  <= cnv_s1_reg;
            cnv_s3_reg  <= cnv_s2_reg;
        end
    end

    // shift engine and serial pins
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            in_sh_reg                 <= {`ASCP_WORD_W{1'b0}};
            bit_cnt_reg               <= {`ASCP_BITCNT_W{1'b0}};
            out_sh_reg                <= {`ASCP_OUT_W{1'b0}};
            first_reg                 <= 1'b0;
            o_serial_result_out       <= 1'b0;
            o_diff_serial_result_out  <= 1'b0;
            o_echoed_shift_clock_out  <= 1'b0;
            o_diff_shift_clock_out    <= 1'b0;
            o_serial_result_oe_n      <= 1'b1;
            o_echoed_shift_clock_oe_n <= 1'b1;
            o_diff_serial_result_oe_n <= 1'b1;
            o_diff_shift_clock_oe_n   <= 1'b1;
            o_se_input_en             <= 1'b0;
            o_diff_term_en            <= 1'b0;
            o_word_ready              <= 1'b0;
        end else if (i_clk_en) begin
            if (cs_s2_reg) begin
                // idle: reload latest frame
                bit_cnt_reg <= {`ASCP_BITCNT_W{1'b0}};
                out_sh_reg  <= out_word_reg;             // RULE_07
                first_reg   <= 1'b1;
            end else if (act_edge) begin
                // one bit in, next bit out
                in_sh_reg   <= word_now;
                bit_cnt_reg <= bit_cnt_reg + 1'b1;
                out_sh_reg  <= {out_sh_reg[`ASCP_OUT_MSB-1:0],
                                1'b0};                   // RULE_01 RULE_13
                if (word_push && fifo_in_ready) begin
                    first_reg <= 1'b0;
                end
            end
            o_serial_result_out      <= dout_next;
            o_diff_serial_result_out <= dout_next;
            // echo clock: toggles on rises, cleared as busy falls
            if (state_reg == ST_CONV && i_core_done) begin
                o_echoed_shift_clock_out <= 1'b0;        // RULE_05
            end else if (sel && ck_rise) begin
                o_echoed_shift_clock_out <=
                    ~o_echoed_shift_clock_out;           // RULE_04
            end
            // forwarded copy shares the data's register stage
            o_diff_shift_clock_out <= ck_s2_reg & sel;   // RULE_15
            // pin enables, low while driving
            o_serial_result_oe_n      <= cs_s2_reg | mode_s2_reg; // RULE_09
            o_echoed_shift_clock_oe_n <= cs_s2_reg | mode_s2_reg;
            o_diff_serial_result_oe_n <= cs_s2_reg | ~mode_s2_reg; // RULE_11
            o_diff_shift_clock_oe_n   <= cs_s2_reg | ~mode_s2_reg;
            o_se_input_en             <= ~mode_s2_reg;   // RULE_11
            o_diff_term_en            <= ~cs_s2_reg & mode_s2_reg; // RULE_16
            o_word_ready              <= fifo_in_ready;
        end
    end

    // sequence table bookkeeping
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wr_ptr_reg <= {`ASCP_SEQ_AW{1'b0}};
            rd_ptr_reg <= {`ASCP_SEQ_AW{1'b0}};
            len_reg    <= {`ASCP_LEN_W{1'b0}};
        end else if (i_clk_en) begin
            if (seq_we && fifo_out_data[`ASCP_CFG_W]) begin
                // first word of a frame restarts the sequence
                wr_ptr_reg <= {{(`ASCP_SEQ_AW-1){1'b0}}, 1'b1};
                rd_ptr_reg <= {`ASCP_SEQ_AW{1'b0}};
                len_reg    <= {{(`ASCP_LEN_W-1){1'b0}}, 1'b1};
            end else if (seq_we) begin
                // later words extend it; a ninth wraps and overwrites
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
                if (len_reg != `ASCP_SEQ_DEPTH) begin
                    len_reg <= len_reg + 1'b1;
                end
            end else if (state_reg == ST_IDLE && cnv_rise) begin
                // step through the programmed sequence
                if ({1'b0, rd_ptr_reg} + 1'b1 >= len_reg) begin
                    rd_ptr_reg <= {`ASCP_SEQ_AW{1'b0}};  // RULE_08
                end else begin
                    rd_ptr_reg <= rd_ptr_reg + 1'b1;
                end
            end
        end
    end

    // conversion control
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg        <= ST_IDLE;
            conv_cfg_reg     <= `ASCP_CFG_RESET;
            out_word_reg     <= {`ASCP_OUT_W{1'b0}};
            o_core_start     <= 1'b0;
            o_busy           <= 1'b0;
            o_core_channel   <= 3'h0;
            o_core_range     <= 3'h0;
            o_core_span_wide <= 1'b0;
            o_core_span_full <= 1'b0;
        end else if (i_clk_en) begin
            o_core_start <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    // select and bus state play no part here
                    if (cnv_rise) begin                  // RULE_22
                        state_reg        <= ST_CONV;
                        o_busy           <= 1'b1;        // RULE_23
                        o_core_start     <= 1'b1;
                        conv_cfg_reg     <= next_cfg;
                        o_core_channel   <= next_cfg[`ASCP_CFG_CH_MSB:
                                                     `ASCP_CFG_CH_LSB]; // RULE_21
                        o_core_range     <= next_cfg[`ASCP_CFG_RNG_MSB:
                                                     `ASCP_CFG_RNG_LSB];
                        o_core_span_wide <= next_cfg[`ASCP_RNG_WIDE];  // RULE_19
                        o_core_span_full <= next_cfg[`ASCP_RNG_FULL];  // RULE_19
                    end
                end
                ST_CONV: begin
                    // result frame: code, channel, range, pad
                    if (i_core_done) begin
                        state_reg    <= ST_IDLE;
                        o_busy       <= 1'b0;            // RULE_23
                        out_word_reg <= {fmt_result, conv_cfg_reg,
                                         `ASCP_OUT_PAD}; // RULE_07
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    o_busy    <= 1'b0;
                end
            endcase
        end
    end

endmodule // ascp_top

// ### test/ascp_host_model.sv
`timescale 1ns/1ps

// host stand-in
module ascp_host_model (
    // clock and strap
    input  wire  i_mclk,
    input  wire  i_mode_diff,
    // result data and returned clock
    input  wire  i_sdo,
    input  wire  i_fwd,
    // pins driven towards the block
    output logic o_cs_n,
    output logic o_sck,
    output logic o_sdi
);
    logic [24:0] cap;   // first bit taken before any edge
    logic        fwd_q; // last returned clock level
    int          nchg;  // returned clock edges
    initial begin
        o_cs_n = 1'b1;
        o_sck  = 1'b0;
        o_sdi  = 1'b0;
    end
    // sample on mclk fall, outputs settled
    always @(negedge i_mclk) begin
        fwd_q <= i_fwd;
        if (i_fwd !== fwd_q && !o_cs_n) begin
            cap  <= {cap[23:0], i_sdo};
            nchg <= nchg + 1;
        end
    end
    task automatic wt(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    // n edges, msb first from d[71]
    task automatic frame(input logic [71:0] d, input int n);
        nchg = 0;
        o_sck = o_sck & ~i_mode_diff;
        wt(4);
        o_cs_n = 1'b0;
        wt(6);
        cap = {cap[23:0], i_sdo};
        for (int k = 0; k < n; k++) begin
            o_sdi = d[71-k];
            if (!i_mode_diff)
                o_sck = 1'b0;
            wt(4);
            o_sck = i_mode_diff ? ~o_sck : 1'b1;
            wt(4);
        end
        o_sdi = ~o_sdi; // released line: no stale value
        wt(4);
        o_cs_n = 1'b1;
        wt(8);
    endtask
    // word clocked while deselected
    task automatic stray(input logic [7:0] w);
        for (int k = 0; k < 8; k++) begin
            o_sdi = w[7-k];
            o_sck = 1'b0;
            wt(4);
            o_sck = 1'b1;
            wt(4);
        end
        o_sck = 1'b0;
    endtask
endmodule // ascp_host_model

// ### test/ascp_top_asserts.sv
`timescale 1ns/1ps

// port checker
module ascp_top_asserts (
    input wire i_mclk, i_sys_rst, i_clk_en, i_mode_diff, i_cs_n,
    input wire i_conversion_start, i_core_done, o_serial_result_oe_n,
    input wire o_diff_serial_result_oe_n, o_echoed_shift_clock_out,
    input wire o_diff_term_en, o_se_input_en, o_core_start, o_busy
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    chk_se_mode: assert property (!o_serial_result_oe_n |-> !i_mode_diff)
        else $error("se pins in diff mode");
    chk_diff_mode: assert property (!o_diff_serial_result_oe_n |-> i_mode_diff)
        else $error("diff pins in se mode");
    chk_se_input: assert property ($stable(i_mode_diff) [*6] |-> o_se_input_en == !i_mode_diff)
        else $error("se input enable");
    chk_desel_off: assert property (i_cs_n [*5] |-> o_serial_result_oe_n && o_diff_serial_result_oe_n && !o_diff_term_en)
        else $error("active while deselected");
    chk_busy_rise: assert property ($rose(o_busy) |-> o_core_start)
        else $error("busy without start");
    chk_start_once: assert property (o_core_start |=> !o_core_start && o_busy)
        else $error("start not single");
    chk_busy_hold: assert property (o_busy && !i_core_done |=> o_busy)
        else $error("busy dropped before done");
    chk_done_idle: assert property (i_core_done |=> !o_busy)
        else $error("busy after done");
    chk_echo_low: assert property ($fell(o_busy) |-> !o_echoed_shift_clock_out)
        else $error("echo not low");
    chk_cnv_go: assert property ($rose(i_conversion_start) && !o_busy && i_clk_en |-> ##[1:5] o_busy)
        else $error("start ignored");
endmodule // ascp_top_asserts

bind ascp_top ascp_top_asserts ascp_top_asserts_i (.*);

// ### test/ascp_top_tb_top.sv
`timescale 1ns/1ps

module ascp_top_tb_top;
    logic        i_mclk, i_sys_rst, i_clk_en, i_mode_diff;
    logic        i_conversion_start, i_core_done;
    logic [15:0] i_core_result;
    wire         i_cs_n, i_shift_clock_in, i_serial_control_in;
    wire         i_diff_shift_clock_in, i_diff_serial_control_in;
    wire         o_serial_result_out, o_serial_result_oe_n;
    wire         o_echoed_shift_clock_out, o_echoed_shift_clock_oe_n;
    wire         o_diff_serial_result_out, o_diff_serial_result_oe_n;
    wire         o_diff_shift_clock_out, o_diff_shift_clock_oe_n;
    wire         o_se_input_en, o_diff_term_en, o_core_start;
    wire         o_core_span_wide, o_core_span_full, o_busy, o_word_ready;
    wire [2:0]   o_core_channel, o_core_range;
    int          error_cnt, comparisons, cyc, lat, cnt;
    // one host drives both pin pairs
    assign i_diff_shift_clock_in    = i_shift_clock_in;
    assign i_diff_serial_control_in = i_serial_control_in;
    ascp_top ascp_top_i (.*);
    ascp_host_model ascp_host_model_i (
        .i_mclk      (i_mclk),
        .i_mode_diff (i_mode_diff),
        .i_sdo       (i_mode_diff ? o_diff_serial_result_out : o_serial_result_out),
        .i_fwd       (i_mode_diff ? o_diff_shift_clock_out : o_echoed_shift_clock_out),
        .o_cs_n      (i_cs_n),
        .o_sck       (i_shift_clock_in),
        .o_sdi       (i_serial_control_in)
    );
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    // core stand-in: done lat cycles after start
    always @(negedge i_mclk) begin
        i_core_done <= 1'b0;
        if (o_core_start)
            cnt <= lat;
        else if (cnt > 0) begin
            cnt <= cnt - 1;
            i_core_done <= (cnt == 1);
        end
    end
    // hang guard
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            print_verdict;
        end
    end
    task automatic print_verdict;
        if (error_cnt == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, e, input string n);
        comparisons = comparisons + 1;
        if (s !== e) begin
            error_cnt = error_cnt + 1;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // one conversion, config from the sequence
    task automatic conv(input logic [15:0] r, input logic [2:0] c, input logic [2:0] g);
        i_core_result = r;
        i_conversion_start = 1'b1;
        ascp_host_model_i.wt(6);
        chk(o_busy, 1, "busy");
        chk({o_core_channel, o_core_range, o_core_span_wide, o_core_span_full}, {c, g, g[2], g[0]}, "cfg");
        i_conversion_start = 1'b0;
        ascp_host_model_i.wt(lat + 4);
        chk(o_busy, 0, "idle");
    endtask
    // all channels and codes; each frame reads the last result
    task automatic t_ranges;
        logic [15:0] r;
        logic [2:0]  c, g;
        for (int i = 0; i < 9; i++) begin
            ascp_host_model_i.frame({2'h2, ~i[2:0], i[2:0], 64'h0}, 24);
            if (i > 0) begin
                chk(ascp_host_model_i.cap[24:1], {r ^ {g[1], 15'h0}, c, g, 2'h0}, "frame");
                chk(ascp_host_model_i.nchg, 24, "echo");
            end
            c = ~i[2:0];
            g = i[2:0];
            r = {4{i[3:0]}} ^ 16'h5A3C;
            if (i < 8)
                conv(r, c, g);
        end
    endtask
    // frozen start edge, stray and all-zero words keep the sequence
    task automatic t_keep;
        i_clk_en = 1'b0;
        i_conversion_start = 1'b1;
        ascp_host_model_i.wt(2);
        i_conversion_start = 1'b0;
        ascp_host_model_i.wt(2);
        i_clk_en = 1'b1;
        ascp_host_model_i.wt(6);
        chk(o_busy, 0, "frozen");
        ascp_host_model_i.stray(8'h9B);
        ascp_host_model_i.frame(72'h0, 24);
        conv(16'h0F0F, 3'h7, 3'h0);
    endtask
    // double-edge mode
    task automatic t_diff;
        i_mode_diff = 1'b1;
        ascp_host_model_i.wt(8);
        chk({o_se_input_en, o_diff_term_en, o_diff_serial_result_oe_n}, 3'h1, "pads");
        fork
            ascp_host_model_i.frame({8'hAE, 64'h0}, 24);
            begin
                ascp_host_model_i.wt(14);
                chk({o_se_input_en, o_diff_term_en}, 2'h1, "term");
            end
        join
        chk(ascp_host_model_i.cap[24:1], {16'h0F0F, 3'h7, 3'h0, 2'h0}, "dframe");
        chk(ascp_host_model_i.nchg, 24, "fwd");
        conv(16'h8001, 3'h5, 3'h6);
        ascp_host_model_i.frame(72'h0, 24);
        chk(ascp_host_model_i.cap[24:1], {16'h0001, 3'h5, 3'h6, 2'h0}, "bipolar");
    endtask
    // nine words in a long conversion fill the queue
    task automatic t_fill;
        lat = 900;
        i_conversion_start = 1'b1;
        ascp_host_model_i.wt(6);
        i_conversion_start = 1'b0;
        ascp_host_model_i.frame({9{8'h8A}}, 72);
        chk(o_word_ready, 0, "full");
        ascp_host_model_i.wt(900);
        chk(o_word_ready, 1, "drained");
    endtask
    initial begin
        i_sys_rst = 1'b1;
        i_clk_en = 1'b1;
        i_mode_diff = 1'b0;
        i_conversion_start = 1'b0;
        i_core_done = 1'b0;
        i_core_result = 16'h0;
        lat = 5;
        ascp_host_model_i.wt(4);
        i_sys_rst = 1'b0;
        ascp_host_model_i.wt(4);
        chk({o_busy, o_serial_result_oe_n, o_diff_serial_result_oe_n}, 3'h3, "reset");
        t_ranges;
        t_keep;
        t_diff;
        t_fill;
        print_verdict;
    end
endmodule // ascp_top_tb_top
